/* File: pkg/snh_pkg.sv */
// snh_pkg: opcodes, feature addresses, status fields, timing counts and carrier types
// assumes a 200 MHz system clock driving a serial NAND flash over four lanes
package snh_pkg;
  // opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] OPC_PAGE_READ = 8'h13;
  localparam logic [7:0] OPC_PROG_EXEC = 8'h10;
  localparam logic [7:0] OPC_GET_FEAT  = 8'h0F;
  localparam logic [7:0] OPC_SET_FEAT  = 8'h1F;
  localparam logic [7:0] OPC_RD_1      = 8'h03;
  localparam logic [7:0] OPC_RD_FAST   = 8'h0B;
  localparam logic [7:0] OPC_RD_2      = 8'h3B;
  localparam logic [7:0] OPC_RD_4      = 8'h6B;
  localparam logic [7:0] OPC_RD_DIO    = 8'hBB;
  localparam logic [7:0] OPC_RD_QIO    = 8'hEB;
  localparam logic [7:0] OPC_LD        = 8'h02;
  localparam logic [7:0] OPC_LD_4      = 8'h32;
  localparam logic [7:0] OPC_LDR       = 8'h84;
  localparam logic [7:0] OPC_LDR_4A    = 8'hC4;
  localparam logic [7:0] OPC_LDR_4B    = 8'h34;
  localparam logic [7:0] OPC_LDR_QIO   = 8'h72;
  // feature addresses and fields
  localparam logic [7:0] FEAT_CONFIG  = 8'hB0;
  localparam logic [7:0] FEAT_STATUS  = 8'hC0;
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_WEL_BIT   = 1;
  localparam int         ST_PFAIL_BIT = 3;
  localparam int         ST_ECC_LO    = 4;
  localparam int         ST_ECC_HI    = 5;
  localparam int         CFG_QUAD_BIT = 0;
  // cache geometry
  localparam logic [11:0] CACHE_BYTES = 12'h840;
  localparam logic [11:0] COL_MAX     = 12'h83F;
  // frame layout
  localparam logic [4:0] ADDR_BITS_ROW  = 5'h18;
  localparam logic [4:0] ADDR_BITS_COL  = 5'h10;
  localparam logic [4:0] ADDR_BITS_FEAT = 5'h08;
  localparam logic [4:0] CMD_CLKS       = 5'h08;
  localparam logic [3:0] DUMMY_SINGLE   = 4'h8;
  localparam logic [3:0] DUMMY_DIO      = 4'h4;
  localparam logic [1:0] LW_1 = 2'h0;
  localparam logic [1:0] LW_2 = 2'h1;
  localparam logic [1:0] LW_4 = 2'h2;
  localparam logic [3:0] LANES_IDLE = 4'hC;
  // timing
  localparam int SYS_CLK_MHZ      = 200;
  localparam int SCLK_PERIOD_NS   = 40;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS * SYS_CLK_MHZ / 2) / 1000;
  localparam int CS_HIGH_NS       = 50;
  localparam int CS_HIGH_CYCLES   = (CS_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [11:0] count;
  } snh_cmd_t;

  typedef struct packed {
    logic       known;
    logic [4:0] addr_bits;
    logic [1:0] addr_w;
    logic [3:0] dummy;
    logic [1:0] data_w;
    logic       rd;
    logic       wr;
    logic       quad;
  } snh_layout_t;

  function automatic snh_layout_t snh_decode(input logic [7:0] opc);
    snh_layout_t l;
    l = '0;
    l.known = 1'b1;
    case (opc)
      OPC_WRITE_ENABLE_CMD: l.known = 1'b1;
      OPC_PAGE_READ, OPC_PROG_EXEC: l.addr_bits = ADDR_BITS_ROW;
      OPC_GET_FEAT: begin
        l.addr_bits = ADDR_BITS_FEAT;
        l.rd = 1'b1;
      end
      OPC_SET_FEAT: l.addr_bits = ADDR_BITS_COL;
      OPC_RD_1, OPC_RD_FAST, OPC_RD_2, OPC_RD_4: begin
        l.addr_bits = ADDR_BITS_COL;
        l.dummy = DUMMY_SINGLE;
        l.rd = 1'b1;
        l.data_w = (opc == OPC_RD_4) ? LW_4 : (opc == OPC_RD_2) ? LW_2 : LW_1;
        l.quad = (opc == OPC_RD_4);
      end
      OPC_RD_DIO: begin
        l.addr_bits = ADDR_BITS_COL;
        l.addr_w = LW_2;
        l.dummy = DUMMY_DIO;
        l.data_w = LW_2;
        l.rd = 1'b1;
      end
      OPC_RD_QIO, OPC_LDR_QIO: begin
        l.addr_bits = ADDR_BITS_COL;
        l.addr_w = LW_4;
        l.data_w = LW_4;
        l.rd = (opc == OPC_RD_QIO);
        l.wr = (opc == OPC_LDR_QIO);
        l.quad = 1'b1;
      end
      OPC_LD, OPC_LDR, OPC_LD_4, OPC_LDR_4A, OPC_LDR_4B: begin
        l.addr_bits = ADDR_BITS_COL;
        l.wr = 1'b1;
        l.quad = !(opc == OPC_LD || opc == OPC_LDR);
        l.data_w = l.quad ? LW_4 : LW_1;
      end
      default: l.known = 1'b0;
    endcase
    return l;
  endfunction

  // serial clocks that carry one byte at a lane width
  function automatic logic [3:0] snh_cpb(input logic [1:0] w);
    return (w == LW_4) ? 4'h2 : (w == LW_2) ? 4'h4 : 4'h8;
  endfunction

  function automatic logic [4:0] snh_clks(input logic [4:0] bits, input logic [1:0] w);
    return (w == LW_4) ? (bits >> 2) : (w == LW_2) ? (bits >> 1) : bits;
  endfunction

  function automatic logic [31:0] snh_shift(input logic [31:0] tx, input logic [1:0] w);
    return (w == LW_4) ? (tx << 4) : (w == LW_2) ? (tx << 2) : (tx << 1);
  endfunction

  // lane levels; lanes 3 and 2 stay high when they carry no data
  function automatic logic [3:0] snh_drive(input logic [31:0] tx, input logic [1:0] w);
    if (w == LW_4) return tx[31:28];
    if (w == LW_2) return {2'h3, tx[31:30]};
    return {3'h6, tx[31]};
  endfunction
endpackage

/* File: core/snh_sclk_div.sv */
// snh_sclk_div: serial clock divider, low phase first, stops low when run drops
// assumes run falls only in a cycle where period_end is high or the clock is idle
`timescale 1ns/1ps
`default_nettype none
module snh_sclk_div import snh_pkg::*; #(
  parameter int HALF = SCLK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // control
  input  wire logic run,
  output logic      sclk,
  output logic      period_end
);
  if (HALF < 3 || HALF > 255) begin : g_chk
    $error("snh_sclk_div: HALF out of range");
  end

  logic [7:0] cnt_reg;
  logic       sclk_reg;
  wire        at_top = (cnt_reg == 8'(HALF - 1));

  assign sclk       = sclk_reg;
  assign period_end = run && sclk_reg && at_top;

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      cnt_reg  <= 8'h00;
      sclk_reg <= 1'b0;
    end else if (at_top) begin
      cnt_reg  <= 8'h00;
      sclk_reg <= !sclk_reg;
    end else begin
      cnt_reg  <= cnt_reg + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: core/snh_fifo.sv */
// snh_fifo: synchronous valid/ready FIFO on the write data path
// assumes one clock; DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none
module snh_fifo import snh_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("snh_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             ready_reg;
  wire              push    = in_valid && ready_reg;
  wire              pop     = out_valid && out_ready;
  wire  [AW:0]      wr_next = wr_ptr_reg + (AW + 1)'(push);
  wire  [AW:0]      rd_next = rd_ptr_reg + (AW + 1)'(pop);
  wire  [AW:0]      fill    = wr_next - rd_next;
  // a byte written into the slot read next goes straight to the read register
  wire              fwd     = push && (wr_ptr_reg[AW-1:0] == rd_next[AW-1:0]);
  logic [WIDTH-1:0] rdata_reg;

  assign in_ready  = ready_reg;
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = rdata_reg;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
    rdata_reg <= fwd ? in_data : mem[rd_next[AW-1:0]];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      ready_reg  <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_next;
      rd_ptr_reg <= rd_next;
      ready_reg  <= (fill != (AW + 1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

/* File: core/snh_host.sv */
// snh_host: host controller for a serial NAND flash, page read/program and cache access
// assumes one flash on the lanes and a user that waits for cmd_ready between commands
// Contract
// [R1] page read opcode starts an array-to-cache load before cache reads make sense
// [R2] device keeps the busy bit set during the load, clears it after
// [R3] with ecc enabled the device reports correction outcome in two ecc bits
// [R4] with ecc enabled the page passes a bch decoder before the cache
// [R5] page read carries a 24-bit row; host polls busy until it reads zero
// [R6] cache contents are read with single, fast, dual, quad, dual-io or quad-io opcodes
// [R7] cache read address is 16 bits: 4 wrap bits then 12 column bits
// [R8] wrap bits 3:2 select 2112, 2048, 64 or 16 byte wrap lengths
// [R9] host gives a starting column from 0 to 2111 for cache reads
// [R10] device wraps within the region until chip select rises
// [R11] host sets quad_enable before quad-output or quad-io cache reads
// [R12] dual-io cache read sends address and takes data over two lanes
// [R13] quad-io cache read sends address and takes data over four lanes
// [R14] program: load cache, write enable, program execute, poll busy, check fail bit
// [R15] every cache load takes 4 dummy bits and a 12-bit column
// [R16] device drops load bytes beyond 2112 in one transfer
// [R17] chip select stays low through a cache load; rising aborts it
// [R18] program execute without write_enable_latch is ignored, fail bit stays zero
// [R19] host sets quad_enable before quad cache load opcodes
// [R20] random-data loads change only the addressed cache bytes
// [R21] internal move: page read, random loads, write enable, execute, then poll
// [R22] program execute takes a 24-bit row and holds busy until done
// [R23] write enable sets the latch; device clears it after program or erase
// [R24] features are read and written by one-byte feature address
// [R25] device allows quad operations only with quad_enable set
// [R26] during busy the device answers status polls and starts nothing else
`timescale 1ns/1ps
`default_nettype none
module snh_host import snh_pkg::*; #(
  parameter int HALF       = SCLK_HALF_CYCLES,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // command port
  input  wire logic       cmd_valid,
  input  wire snh_cmd_t   cmd,
  output logic            cmd_ready,
  // completion
  output logic            cmd_done,
  output logic            cmd_error,
  output logic [7:0]      status,
  // write data
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  // read data
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  // serial pins
  output logic            spi_clk,
  output logic            spi_cs_n,
  input  wire logic [3:0] lane_in,
  output logic [3:0]      lane_out,
  output logic [3:0]      lane_oe
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("snh_host: FIFO_DEPTH too small");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_GAP} snh_st_t;

  snh_st_t     st_reg, st_next;
  snh_cmd_t    cmd_reg, cmd_next;
  snh_layout_t lay_reg, lay_next;
  logic [31:0] tx_reg, tx_next;
  logic [7:0]  rx_reg, rx_next;
  logic [4:0]  clk_cnt_reg, clk_cnt_next;
  logic [11:0] byte_cnt_reg, byte_cnt_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  gap_reg, gap_next;
  logic        need_reg, need_next;
  logic        poll_reg, poll_next;
  logic        qe_reg, qe_next;
  logic        wel_reg, wel_next;
  logic        ready_reg, done_reg, done_next, err_reg, err_next;
  logic        rdv_reg, rdv_next;
  logic [7:0]  rdd_reg, rdd_next, status_reg, status_next;
  logic        cs_n_reg;
  logic [3:0]  out_reg, oe_reg, out_next, oe_next;
  logic [3:0]  in_meta_reg, in_sync_reg;
  logic        pe, fifo_valid;
  logic [7:0]  fifo_data;

  function automatic snh_st_t next_phase(input snh_st_t s, input snh_layout_t l);
    if (s == ST_CMD && l.addr_bits != 5'h00) return ST_ADDR;
    if ((s == ST_CMD || s == ST_ADDR) && l.dummy != 4'h0) return ST_DUMMY;
    if (l.rd || l.wr) return ST_DATA;
    return ST_GAP;
  endfunction

  localparam logic [7:0] GAP_LOAD = 8'(CS_HIGH_CYCLES - 1);
  localparam snh_cmd_t   POLL_CMD = '{OPC_GET_FEAT, {16'h0000, FEAT_STATUS}, 12'h001};

  // decode and selection
  wire         active   = (st_reg inside {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA});
  wire         run      = active && !need_reg;
  wire  [1:0]  cur_w    = (st_reg == ST_CMD) ? LW_1 :
                          (st_reg == ST_ADDR) ? lay_reg.addr_w : lay_reg.data_w;
  wire  [7:0]  rx_sh    = (cur_w == LW_4) ? {rx_reg[3:0], in_sync_reg} :
                          (cur_w == LW_2) ? {rx_reg[5:0], in_sync_reg[1:0]} :
                          {rx_reg[6:0], in_sync_reg[1]};
  wire         take     = cmd_valid && ready_reg;
  snh_layout_t in_lay;
  assign in_lay = snh_decode(cmd.opcode);
  // [R6] cache read opcodes
  wire         cache_rd = in_lay.rd && in_lay.addr_bits == ADDR_BITS_COL;
  // [R9] column range guard
  wire         bad_col  = cache_rd && (cmd.addr[11:0] > COL_MAX);
  wire         bad_len  = (in_lay.rd || in_lay.wr) && cmd.count == 12'h000 ||
                          in_lay.wr && cmd.count > CACHE_BYTES;
  // [R11] [R19] quad opcodes need quad_enable
  wire         bad_quad = in_lay.quad && !qe_reg;
  // [R14] execute needs write enable first
  wire         bad_wel  = (cmd.opcode == OPC_PROG_EXEC) && !wel_reg;
  wire         refuse   = !in_lay.known || bad_col || bad_len || bad_quad || bad_wel;
  wire         gap_end  = (st_reg == ST_GAP) && (gap_reg == 8'h00);
  // [R1] row ops start array work
  wire         array_op = (cmd_reg.opcode == OPC_PAGE_READ) ||
                          (cmd_reg.opcode == OPC_PROG_EXEC);
  // [R5] keep polling while the busy bit reads one
  wire         again    = poll_reg ? status_reg[ST_BUSY_BIT] : array_op;
  wire         start_pl = gap_end && again;
  wire         start    = (take && !refuse) || start_pl;
  snh_cmd_t    start_c;
  assign start_c = start_pl ? POLL_CMD : cmd;
  wire         fifo_pop = (st_reg == ST_DATA) && need_reg;

  always_comb begin
    st_next       = st_reg;
    cmd_next      = cmd_reg;
    lay_next      = lay_reg;
    tx_next       = tx_reg;
    rx_next       = rx_reg;
    clk_cnt_next  = clk_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    bit_cnt_next  = bit_cnt_reg;
    gap_next      = gap_reg;
    need_next     = need_reg;
    poll_next     = poll_reg;
    qe_next       = qe_reg;
    wel_next      = wel_reg;
    status_next   = status_reg;
    rdd_next      = rdd_reg;
    done_next     = 1'b0;
    err_next      = take && refuse;
    rdv_next      = 1'b0;
    if (start) begin
      st_next      = ST_CMD;
      cmd_next     = start_c;
      lay_next     = snh_decode(start_c.opcode);
      tx_next      = {start_c.opcode, 24'h00_0000};
      clk_cnt_next = CMD_CLKS;
      poll_next    = start_pl;
      if (!start_pl && cmd.opcode == OPC_WRITE_ENABLE_CMD) begin
        wel_next = 1'b1;
      end
      // [R23] device drops the latch once execute is sent
      if (!start_pl && cmd.opcode == OPC_PROG_EXEC) begin
        wel_next = 1'b0;
      end
      if (!start_pl && cmd.opcode == OPC_SET_FEAT && cmd.addr[15:8] == FEAT_CONFIG) begin
        qe_next = cmd.addr[CFG_QUAD_BIT];
      end
    end else if (gap_end) begin
      st_next   = ST_IDLE;
      poll_next = 1'b0;
      done_next = 1'b1;
    end else if (st_reg == ST_GAP) begin
      gap_next = gap_reg - 8'h01;
    end else if (fifo_pop) begin
      // [R17] wait for data with chip select held low
      if (fifo_valid) begin
        tx_next   = {fifo_data, 24'h00_0000};
        need_next = 1'b0;
      end
    end else if (pe) begin
      tx_next      = snh_shift(tx_reg, cur_w);
      clk_cnt_next = clk_cnt_reg - 5'h01;
      if (st_reg == ST_DATA) begin
        bit_cnt_next = bit_cnt_reg - 4'h1;
        rx_next      = rx_sh;
        if (bit_cnt_reg == 4'h1) begin
          bit_cnt_next  = snh_cpb(lay_reg.data_w);
          byte_cnt_next = byte_cnt_reg - 12'h001;
          if (lay_reg.rd && poll_reg) begin
            status_next = rx_sh;
          end else if (lay_reg.rd) begin
            rdv_next = 1'b1;
            rdd_next = rx_sh;
          end
          if (byte_cnt_reg == 12'h001) begin
            st_next  = ST_GAP;
            gap_next = GAP_LOAD;
          end else begin
            need_next = lay_reg.wr;
          end
        end
      end else if (clk_cnt_reg == 5'h01) begin
        st_next = next_phase(st_reg, lay_reg);
        case (st_next)
          ST_ADDR: begin
            tx_next      = {cmd_reg.addr, 8'h00} << (ADDR_BITS_ROW - lay_reg.addr_bits);
            clk_cnt_next = snh_clks(lay_reg.addr_bits, lay_reg.addr_w);
          end
          ST_DUMMY: clk_cnt_next = {1'b0, lay_reg.dummy};
          ST_DATA: begin
            byte_cnt_next = cmd_reg.count;
            bit_cnt_next  = snh_cpb(lay_reg.data_w);
            need_next     = lay_reg.wr;
          end
          default: gap_next = GAP_LOAD;
        endcase
      end
    end
  end

  // lane levels and enables for the next state
  wire  [1:0] w_next   = (st_next == ST_CMD) ? LW_1 :
                         (st_next == ST_ADDR) ? lay_next.addr_w : lay_next.data_w;
  wire        act_next = (st_next inside {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA});
  wire        drv_next = (st_next inside {ST_CMD, ST_ADDR}) ||
                         (st_next == ST_DATA && lay_next.wr);
  // [R12] [R13] address and data lanes follow the opcode width
  assign out_next = drv_next ? snh_drive(tx_next, w_next) : LANES_IDLE;
  assign oe_next  = drv_next ? ((w_next == LW_1) ? 4'hD : 4'hF) :
                    !act_next ? 4'hD :
                    lay_next.quad ? 4'h0 : (lay_next.data_w == LW_2) ? 4'hC : 4'hD;

  always_ff @(posedge sys_clk) begin
    in_meta_reg <= lane_in;
    in_sync_reg <= in_meta_reg;
  end

  always_ff @(posedge sys_clk) begin
    cmd_reg       <= cmd_next;
    lay_reg       <= lay_next;
    tx_reg        <= tx_next;
    rx_reg        <= rx_next;
    clk_cnt_reg   <= clk_cnt_next;
    byte_cnt_reg  <= byte_cnt_next;
    bit_cnt_reg   <= bit_cnt_next;
    gap_reg       <= gap_next;
    rdd_reg       <= rdd_next;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg     <= ST_IDLE;
      need_reg   <= 1'b0;
      poll_reg   <= 1'b0;
      qe_reg     <= 1'b0;
      wel_reg    <= 1'b0;
      status_reg <= 8'h00;
      ready_reg  <= 1'b0;
      done_reg   <= 1'b0;
      err_reg    <= 1'b0;
      rdv_reg    <= 1'b0;
      cs_n_reg   <= 1'b1;
      out_reg    <= LANES_IDLE;
      oe_reg     <= 4'hD;
    end else begin
      st_reg     <= st_next;
      need_reg   <= need_next;
      poll_reg   <= poll_next;
      qe_reg     <= qe_next;
      wel_reg    <= wel_next;
      status_reg <= status_next;
      ready_reg  <= (st_next == ST_IDLE);
      done_reg   <= done_next;
      err_reg    <= err_next;
      rdv_reg    <= rdv_next;
      cs_n_reg   <= !act_next;
      out_reg    <= out_next;
      oe_reg     <= oe_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign cmd_done  = done_reg;
  assign cmd_error = err_reg;
  assign status    = status_reg;
  assign rd_valid  = rdv_reg;
  assign rd_data   = rdd_reg;
  assign spi_cs_n  = cs_n_reg;
  assign lane_out  = out_reg;
  assign lane_oe   = oe_reg;

  snh_sclk_div #(.HALF(HALF)) u_div (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .run        (run),
    .sclk       (spi_clk),
    .period_end (pe)
  );

  snh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_array_end;
    gap_end && array_op && !poll_reg;
  endsequence
  sequence s_poll_begin;
    st_reg == ST_CMD && cmd_reg.opcode == OPC_GET_FEAT && poll_reg;
  endsequence
  property p_load_then_poll;
    s_array_end |=> s_poll_begin;
  endproperty
  a_load_then_poll: assert property (p_load_then_poll) else $error("no poll after array op"); // [R1]
  property p_done_not_busy;
    done_reg |-> !status_reg[ST_BUSY_BIT];
  endproperty
  a_done_not_busy: assert property (p_done_not_busy) else $error("done while busy"); // [R5]
  property p_quad_read;
    (st_reg == ST_CMD && lay_reg.quad && lay_reg.rd) |-> qe_reg;
  endproperty
  a_quad_read: assert property (p_quad_read) else $error("quad read without enable"); // [R11]
  property p_quad_load;
    (st_reg == ST_CMD && lay_reg.quad && lay_reg.wr) |-> qe_reg;
  endproperty
  a_quad_load: assert property (p_quad_load) else $error("quad load without enable"); // [R19]
  property p_col_range;
    (st_reg == ST_ADDR && lay_reg.rd && lay_reg.addr_bits == ADDR_BITS_COL)
      |-> cmd_reg.addr[11:0] <= COL_MAX;
  endproperty
  a_col_range: assert property (p_col_range) else $error("column out of range"); // [R9]
  property p_exec_wel;
    (take && cmd.opcode == OPC_PROG_EXEC && !refuse) |-> wel_reg ##1 !wel_reg;
  endproperty
  a_exec_wel: assert property (p_exec_wel) else $error("execute without write enable"); // [R14]
  property p_cs_hold;
    (st_reg == ST_DATA && lay_reg.wr) |-> !spi_cs_n ##1 (!spi_cs_n || st_reg == ST_GAP);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("chip select rose in load"); // [R17]
  property p_dual_io;
    (st_reg == ST_ADDR && cmd_reg.opcode == OPC_RD_DIO) |-> lane_oe[1:0] == 2'h3;
  endproperty
  a_dual_io: assert property (p_dual_io) else $error("dual address lanes not driven"); // [R12]
  property p_quad_io;
    (st_reg == ST_DATA && cmd_reg.opcode == OPC_RD_QIO) |-> lane_oe == 4'h0;
  endproperty
  a_quad_io: assert property (p_quad_io) else $error("quad data lanes driven"); // [R13]
  property p_refuse;
    (take && refuse) |=> cmd_error && st_reg == ST_IDLE && spi_cs_n;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused command started"); // [R6]
endmodule
`default_nettype wire

/* File: dv/snh_flash_model.sv */
// snh_flash_model: single-lane serial nand flash
// assumes mode 0 frames from the host
`timescale 1ns/1ps
`default_nettype none
module snh_flash_model (
  // serial pins
  input  wire logic       spi_clk,
  input  wire logic       spi_cs_n,
  input  wire logic [3:0] lanes,
  output logic            so,
  output logic            so_en
);
  logic [7:0]  cache [0:2111];
  logic [7:0]  op, sh, ob;
  logic [23:0] a;
  logic [11:0] col;
  logic [7:0]  st = 8'h00;
  int          n, wl;
  initial so = 1'b0;
  initial so_en = 1'b0;
  always @(negedge spi_cs_n) n = 0;
  always @(posedge spi_clk) if (!spi_cs_n) begin
    sh = {sh[6:0], lanes[0]};
    n++;
    if (n == 8) op = sh;
    if (n % 8 == 0 && n > 8 && n <= 32) a = {a[15:0], sh};
    if (n == 24) begin
      col = a[11:0];
      wl = a[15] ? (a[14] ? 16 : 64) : (a[14] ? 2048 : 2112);
    end
    if (n % 8 == 0 && n > 24 && (op == 8'h02 || op == 8'h84) && col < 2112) begin
      cache[col] = sh;
      col++;
    end
  end
  always @(negedge spi_clk) if (!spi_cs_n && (op == 8'h0F && n >= 16 || op == 8'h03 && n >= 32)) begin
    if (n % 8 == 0) begin
      ob = (op == 8'h0F) ? st : cache[col];
      if (op == 8'h03) col = ((col + 1) % wl == 0) ? col + 1 - wl : col + 1;
    end
    so_en = 1'b1;
    so = ob[7 - n % 8];
  end
  always @(posedge spi_cs_n) so_en = 1'b0;
  always @(posedge spi_cs_n) begin
    if (op == 8'h06) st[1] = 1'b1;
    if (op == 8'h13 || (op == 8'h10 && st[1])) begin
      st[1] = st[1] && op != 8'h10;
      st[0] = 1'b1;
      #2000 st[0] = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_snh_host.sv */
// tb_snh_host: command sequences against the flash model
// assumes design and model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_snh_host import snh_pkg::*;;
  logic       sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
  snh_cmd_t   cmd = '0;
  logic [7:0] status, rd_data, wr_data = 8'h00;
  logic       cmd_ready, cmd_done, cmd_error, wr_ready, rd_valid, spi_clk, spi_cs_n, so, so_en;
  logic [3:0] lane_in, lane_out, lane_oe;
  logic [7:0] rq[$];
  int         miscompares = 0, cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rd_valid) rq.push_back(rd_data);
  // lanes 2 and 3 pulled high; released lane 1 shows so while so_en is high, else ~so; released lane 0 shows its inverse
  assign lane_in = {lane_oe[3] ? lane_out[3] : 1'b1, lane_oe[2] ? lane_out[2] : 1'b1,
    lane_oe[1] ? lane_out[1] : (so_en ? so : ~so), lane_oe[0] ? lane_out[0] : ~lane_out[0]};
  snh_host uut (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error), .status(status),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .lane_in(lane_in),
    .lane_out(lane_out), .lane_oe(lane_oe));
  snh_flash_model dev (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .lanes(lane_in), .so(so),
    .so_en(so_en));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic issue(input logic [7:0] op, input logic [23:0] ad, input logic [11:0] n,
                       input logic err);
    int t;
    cmd_valid <= 1'b1;
    cmd <= '{op, ad, n};
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (cmd_done !== 1'b1 && cmd_error !== 1'b1 && t < 9000);
    chk("cmd_end", 8'h01, {7'h00, cmd_done | cmd_error});
    chk("cmd_error", {7'h00, err}, {7'h00, cmd_error});
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(5 * 30000);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    issue(8'h13, 24'h00_0040, 12'h000, 1'b0);
    chk("busy", 8'h00, {7'h00, status[0]});
    for (int i = 0; i < 16; i++) begin
      wr_valid <= 1'b1;
      wr_data <= 8'h10 + i[7:0];
      do @(posedge sys_clk); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
    issue(8'h84, 24'h00_0010, 12'h010, 1'b0);
    rq.delete();
    issue(8'h03, 24'h00_C01E, 12'h004, 1'b0);
    chk("rd_count", 8'h04, 8'(rq.size()));
    for (int i = 0; i < 4; i++) chk("rd_data", (i < 2 ? 8'h1E : 8'h0E) + i[7:0], rq[i]);
    $display("read test over");
    issue(8'h10, 24'h00_0040, 12'h000, 1'b1);
    issue(8'h06, 24'h00_0000, 12'h000, 1'b0);
    issue(8'h10, 24'h00_0041, 12'h000, 1'b0);
    chk("status", 8'h00, status & 8'h0B);
    $display("program test over");
    issue(8'h6B, 24'h00_0000, 12'h004, 1'b1);
    issue(8'h03, 24'h00_0840, 12'h001, 1'b1);
    issue(8'h9F, 24'h00_0000, 12'h001, 1'b1);
    $display("refusal test over");
    give_verdict();
  end
endmodule
`default_nettype wire
